// ==== wbl_host.sv ====
// Host model driving the register port: writes, reads and table fills
`timescale 1ns/10ps
module wbl_host
    import wbl_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Register port
    output wbl_reg_req_t    req,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid
);
    initial req = '0;

    // Released lines flip so a stale value is never mistaken for a live one
    task automatic idle();
        req = '{1'b0, 1'b0, ~req.addr, ~req.wdata};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        req = '{1'b1, 1'b0, a, d};
        @(posedge clk) #1;
        idle();
    endtask

    // Bounded wait covers both the short and the long read answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk) #1;
        req = '{1'b0, 1'b1, a, ~a};
        @(posedge clk) #1;
        idle();
        for (n = 0; n < 3 && rvalid !== 1'b1; n++) @(posedge clk) #1;
        d = (rvalid === 1'b1) ? rdata : 8'hxx;
    endtask

    // Back-to-back entry writes; the top address is left as the exit code
    task automatic fill(input logic [7:0] key, input logic [7:0] mask);
        int i;
        for (i = 0; i < 255; i++) begin
            @(posedge clk) #1;
            req = '{1'b1, 1'b0, 8'(i), (8'(i) ^ key) & mask};
        end
        @(posedge clk) #1;
        idle();
    endtask
endmodule

// ==== wbl_lut.sv ====
// One colour lookup table: a host write/read port and a pixel read port
`timescale 1ns/10ps
module wbl_lut #(
    parameter int DEPTH = 256,
    parameter int WIDTH = 8
) (
    // Clock
    input  wire logic                     clk,
    // Host port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data,
    // Pixel port
    input  wire logic [$clog2(DEPTH)-1:0] pix_idx,
    output logic      [WIDTH-1:0]         pix_val
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
        pix_val <= mem[pix_idx];
    end
endmodule

// ==== wbl_map.svh ====
// Register offsets, codes and table sizes of the white-balance lookup stage
`ifndef WBL_MAP_SVH
`define WBL_MAP_SVH
`define WBL_LUT_DEPTH       256
`define WBL_LUT_WIDTH       8
`define WBL_REG_PAGE_SEL    8'h2a
`define WBL_REG_PAGE_TOP    8'hff
`define WBL_SEL_RED         8'h70
`define WBL_SEL_GREEN       8'hb0
`define WBL_SEL_BLUE        8'hf0
`define WBL_CMD_ENABLE      8'h20
`define WBL_RST_RDATA       8'h00
`endif

// ==== wbl_pkg.sv ====
// Types shared by the white-balance lookup stage
package wbl_pkg;
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } wbl_pixel_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wbl_reg_req_t;

    // Gray-coded along idle -> red -> green -> blue -> run
    typedef enum logic [2:0] {
        WBL_ST_IDLE  = 3'b000,
        WBL_ST_RED   = 3'b001,
        WBL_ST_GREEN = 3'b011,
        WBL_ST_BLUE  = 3'b010,
        WBL_ST_RUN   = 3'b110
    } wbl_state_t;
endpackage

// ==== wbl_sync.sv ====
// Two-flop synchroniser for one pin-level bit
`timescale 1ns/10ps
module wbl_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Level
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// ==== wbl_white_balance_lut_unit.sv ====
// White-balance lookup stage: paged table loading and pixel remapping
`timescale 1ns/10ps
`include "wbl_map.svh"
module wbl_white_balance_lut_unit
    import wbl_pkg::*;
#(
    parameter int DEPTH = `WBL_LUT_DEPTH,
    parameter int WIDTH = `WBL_LUT_WIDTH
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Register port from the serial-bus target
    input  wire wbl_reg_req_t reg_req,
    output logic [7:0]        reg_rdata_q,
    output logic              reg_rvalid_q,
    output logic              main_wr_q,
    output logic [7:0]        main_addr_q,
    output logic [7:0]        main_wdata_q,
    // Control pins
    input  wire logic         reload_en_pin,
    input  wire logic         six_bit_mode,
    // Pixel stream
    input  wire logic         pix_valid,
    input  wire wbl_pixel_t   pix_in,
    output logic              pix_valid_q,
    output wbl_pixel_t        pix_out_q,
    // Status
    output logic              wb_en_q,
    output logic              page_active_q
);
    localparam int AW = $clog2(DEPTH);

    wbl_state_t st_q, st_d;
    logic       wb_en_d;
    logic       loaded_q, loaded_d;
    logic [1:0] sel_q, sel_d;
    logic       reload_en;
    logic       in_page;
    logic       page_wr;
    logic [2:0] lut_we;
    logic [WIDTH-1:0] rd_r, rd_g, rd_b, pv_r, pv_g, pv_b;
    logic       rd_pend_q, rd_pend_d;
    logic       pv_q;
    logic       main_wr_d, rvalid_d;
    logic [7:0] rdata_d;
    wbl_pixel_t raw_q, out_d;

    // Reload enable arrives as a pin level
    wbl_sync u_sync_reload (
        .clk    (clk),
        .arst_n (arst_n),
        .din    (reload_en_pin),
        .dout   (reload_en)
    );

    assign in_page = (sel_q != 2'd0);
    assign page_wr = reg_req.wr && in_page && (reg_req.addr != `WBL_REG_PAGE_TOP);

    // Table writes: initial load always, later only in reload mode
    always_comb begin
        lut_we = 3'b000;
        if (page_wr && (!loaded_q || reload_en)) begin
            lut_we[sel_q - 2'd1] = 1'b1;
        end
    end

    // Page and enable control
    always_comb begin
        st_d      = st_q;
        sel_d     = sel_q;
        wb_en_d   = wb_en_q;
        loaded_d  = loaded_q;
        main_wr_d = 1'b0;
        if (reg_req.wr) begin
            if (in_page) begin
                if (reg_req.addr == `WBL_REG_PAGE_TOP) begin
                    sel_d = 2'd0;
                end
            end else if (reg_req.addr == `WBL_REG_PAGE_SEL) begin
                case (reg_req.wdata)
                    `WBL_SEL_RED: begin
                        sel_d = 2'd1;
                        st_d  = loaded_q ? st_q : WBL_ST_RED;
                    end
                    `WBL_SEL_GREEN: begin
                        sel_d = 2'd2;
                        st_d  = loaded_q ? st_q : WBL_ST_GREEN;
                    end
                    `WBL_SEL_BLUE: begin
                        sel_d = 2'd3;
                        st_d  = loaded_q ? st_q : WBL_ST_BLUE;
                    end
                    `WBL_CMD_ENABLE: begin
                        wb_en_d  = 1'b1;
                        loaded_d = 1'b1;
                        st_d     = WBL_ST_RUN;
                    end
                    default: begin
                        main_wr_d = 1'b1;
                    end
                endcase
            end else begin
                main_wr_d = 1'b1;
            end
        end
    end

    // Readback only during the initial load; main page reads pass through as zero
    always_comb begin
        rd_pend_d = reg_req.rd && in_page && !loaded_q;
        rvalid_d  = rd_pend_q || (reg_req.rd && !in_page);
        rdata_d   = `WBL_RST_RDATA;
        if (rd_pend_q) begin
            case (sel_q)
                2'd1:    rdata_d = rd_r;
                2'd2:    rdata_d = rd_g;
                2'd3:    rdata_d = rd_b;
                default: rdata_d = `WBL_RST_RDATA;
            endcase
        end
        if (reg_req.rd && in_page && loaded_q) begin
            rvalid_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q          <= WBL_ST_IDLE;
            sel_q         <= 2'd0;
            wb_en_q       <= 1'b0;
            loaded_q      <= 1'b0;
            rd_pend_q     <= 1'b0;
            reg_rdata_q   <= 8'h00;
            reg_rvalid_q  <= 1'b0;
            main_wr_q     <= 1'b0;
            main_addr_q   <= 8'h00;
            main_wdata_q  <= 8'h00;
            page_active_q <= 1'b0;
        end else begin
            st_q          <= st_d;
            sel_q         <= sel_d;
            wb_en_q       <= wb_en_d;
            loaded_q      <= loaded_d;
            rd_pend_q     <= rd_pend_d;
            reg_rdata_q   <= rdata_d;
            reg_rvalid_q  <= rvalid_d;
            main_wr_q     <= main_wr_d;
            main_addr_q   <= reg_req.addr;
            main_wdata_q  <= reg_req.wdata;
            page_active_q <= (sel_d != 2'd0);
        end
    end

    // One table per colour
    wbl_lut #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_lut_red (
        .clk     (clk),
        .wr_en   (lut_we[0]),
        .wr_addr (reg_req.addr[AW-1:0]),
        .wr_data (reg_req.wdata[WIDTH-1:0]),
        .rd_addr (reg_req.addr[AW-1:0]),
        .rd_data (rd_r),
        .pix_idx (pix_in.red[AW-1:0]),
        .pix_val (pv_r)
    );
    wbl_lut #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_lut_green (
        .clk     (clk),
        .wr_en   (lut_we[1]),
        .wr_addr (reg_req.addr[AW-1:0]),
        .wr_data (reg_req.wdata[WIDTH-1:0]),
        .rd_addr (reg_req.addr[AW-1:0]),
        .rd_data (rd_g),
        .pix_idx (pix_in.green[AW-1:0]),
        .pix_val (pv_g)
    );
    wbl_lut #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_lut_blue (
        .clk     (clk),
        .wr_en   (lut_we[2]),
        .wr_addr (reg_req.addr[AW-1:0]),
        .wr_data (reg_req.wdata[WIDTH-1:0]),
        .rd_addr (reg_req.addr[AW-1:0]),
        .rd_data (rd_b),
        .pix_idx (pix_in.blue[AW-1:0]),
        .pix_val (pv_b)
    );

    // Pixel path: two stages, the first is the table read itself.
    // A table write uses its own port beside the pixel read, so a reload never stalls the stream.
    always_comb begin
        out_d = raw_q;
        if (wb_en_q) begin
            out_d.red   = pv_r;
            out_d.green = pv_g;
            out_d.blue  = pv_b;
        end
        if (six_bit_mode) begin
            // 6-bit sources index only every fourth entry
            out_d.red[1:0]   = wb_en_q ? out_d.red[1:0] : 2'b00;
            out_d.green[1:0] = wb_en_q ? out_d.green[1:0] : 2'b00;
            out_d.blue[1:0]  = wb_en_q ? out_d.blue[1:0] : 2'b00;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            raw_q       <= '0;
            pv_q        <= 1'b0;
            pix_valid_q <= 1'b0;
            pix_out_q   <= '0;
        end else begin
            raw_q       <= pix_in;
            pv_q        <= pix_valid;
            pix_valid_q <= pv_q;
            pix_out_q   <= out_d;
        end
    end

    // Checks
    sequence s_enable_cmd;
        reg_req.wr && !in_page && reg_req.addr == `WBL_REG_PAGE_SEL
            && reg_req.wdata == `WBL_CMD_ENABLE;
    endsequence

    property p_enable;
        @(posedge clk) disable iff (!arst_n) s_enable_cmd |=> wb_en_q;
    endproperty
    a_enable: assert property (p_enable) else $error("enable command ignored");

    property p_enable_sticky;
        @(posedge clk) disable iff (!arst_n) wb_en_q |=> wb_en_q;
    endproperty
    a_enable_sticky: assert property (p_enable_sticky) else $error("balance dropped");

    property p_sel_red;
        @(posedge clk) disable iff (!arst_n)
            reg_req.wr && !in_page && reg_req.addr == `WBL_REG_PAGE_SEL
            && reg_req.wdata == `WBL_SEL_RED |=> sel_q == 2'd1 && page_active_q;
    endproperty
    a_sel_red: assert property (p_sel_red) else $error("red page not selected");

    property p_exit;
        @(posedge clk) disable iff (!arst_n)
            reg_req.wr && in_page && reg_req.addr == `WBL_REG_PAGE_TOP |=> !page_active_q;
    endproperty
    a_exit: assert property (p_exit) else $error("page not left");

    property p_no_main_in_page;
        @(posedge clk) disable iff (!arst_n) reg_req.wr && in_page |=> !main_wr_q;
    endproperty
    a_no_main_in_page: assert property (p_no_main_in_page) else $error("main leak");

    property p_locked;
        @(posedge clk) disable iff (!arst_n) loaded_q && !reload_en |-> lut_we == 3'b000;
    endproperty
    a_locked: assert property (p_locked) else $error("table written while locked");

    property p_reload_write;
        @(posedge clk) disable iff (!arst_n) page_wr && reload_en |-> lut_we != 3'b000;
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("reload write lost");

    property p_no_readback;
        @(posedge clk) disable iff (!arst_n)
            reg_req.rd && in_page && loaded_q |=> reg_rvalid_q && reg_rdata_q == 8'h00;
    endproperty
    a_no_readback: assert property (p_no_readback) else $error("readback in reload");

    property p_map_red;
        @(posedge clk) disable iff (!arst_n)
            wb_en_q && $past(wb_en_q) && !six_bit_mode |=> pix_out_q.red == $past(pv_r);
    endproperty
    a_map_red: assert property (p_map_red) else $error("red not remapped");

    property p_valid_lat;
        @(posedge clk) disable iff (!arst_n) pix_valid |-> ##2 pix_valid_q;
    endproperty
    a_valid_lat: assert property (p_valid_lat) else $error("pixel latency wrong");

    property p_run_state;
        @(posedge clk) disable iff (!arst_n) wb_en_q |-> st_q == WBL_ST_RUN;
    endproperty
    a_run_state: assert property (p_run_state) else $error("state not run");
endmodule

// ==== wbl_white_balance_lut_unit_bench.sv ====
// Self-checking bench for the white-balance lookup stage
`timescale 1ns/10ps
`include "wbl_map.svh"
module wbl_white_balance_lut_unit_bench
    import wbl_pkg::*;
();
    localparam logic [7:0] KR = 8'h3c;
    localparam logic [7:0] KG = 8'h96;
    localparam logic [7:0] KB = 8'h5a;
    logic         clk;
    logic         arst_n;
    wbl_reg_req_t req;
    logic [7:0]   rdata;
    logic         rvalid;
    logic         main_wr;
    logic [7:0]   main_addr;
    logic [7:0]   main_wdata;
    logic         reload_en;
    logic         six;
    logic         pix_valid;
    wbl_pixel_t   pix_in;
    logic         pix_valid_q;
    wbl_pixel_t   pix_out;
    logic         wb_en;
    logic         page_act;
    logic [7:0]   rb;
    logic [7:0]   n_main = 8'h00;
    logic         rl;
    logic [7:0]   sel [3] = '{`WBL_SEL_RED, `WBL_SEL_GREEN, `WBL_SEL_BLUE};
    logic [7:0]   key [3] = '{KR, KG, KB};
    logic [7:0]   idx [8] = '{8'h00, 8'h01, 8'h2a, 8'h55, 8'h80, 8'hc3, 8'hfe, 8'h7f};
    wbl_pixel_t   ri [8];
    wbl_pixel_t   ro [8];
    int           miscompares = 0;
    int           n_tests = 0;
    int           c;
    int           k;

    wbl_white_balance_lut_unit u_wbl_white_balance_lut_unit (
        .clk(clk), .arst_n(arst_n), .reg_req(req), .reg_rdata_q(rdata),
        .reg_rvalid_q(rvalid), .main_wr_q(main_wr), .main_addr_q(main_addr),
        .main_wdata_q(main_wdata), .reload_en_pin(reload_en), .six_bit_mode(six),
        .pix_valid(pix_valid), .pix_in(pix_in), .pix_valid_q(pix_valid_q),
        .pix_out_q(pix_out), .wb_en_q(wb_en), .page_active_q(page_act)
    );

    wbl_host u_wbl_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) if (main_wr === 1'b1) n_main++;

    function automatic wbl_pixel_t px(logic [7:0] i);
        return '{i, i ^ 8'h11, i ^ 8'h22};
    endfunction

    function automatic wbl_pixel_t ex(logic [7:0] i);
        return '{(i == 8'h03 && rl) ? 8'hc7 : i ^ KR, i ^ 8'h11 ^ KG, i ^ 8'h22 ^ KB};
    endfunction

    task automatic bad(input string m);
        miscompares++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) bad($sformatf("bit %b, wanted %b", g, e));
    endtask

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) bad($sformatf("byte %h, wanted %h", g, e));
    endtask

    task automatic chk_pix(input wbl_pixel_t g, input wbl_pixel_t e);
        n_tests++;
        if (g !== e) bad($sformatf("pixel %h, wanted %h", g, e));
    endtask

    task automatic pix_chk(input logic [7:0] i, input wbl_pixel_t e);
        pix_in = px(i);
        pix_valid = 1'b1;
        @(posedge clk) #1;
        pix_valid = 1'b0;
        @(posedge clk) #1;
        chk_pix(pix_out, e);
        chk_bit(pix_valid_q, 1'b1);
    endtask

    task automatic complete_run();
        $display("tests %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run is near 8.5 us; a hang is cut well past that
    initial begin
        #100us;
        bad("timeout");
        complete_run();
    end

    initial begin
        arst_n = 1'b0;
        six = 1'b0;
        reload_en = 1'b0;
        pix_valid = 1'b0;
        pix_in = '0;
        rl = 1'b0;
        for (k = 0; k < 8; k++) begin
            ri[k] = px(idx[k]);
            ro[k] = ex(idx[k]);
        end
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        chk_bit(wb_en, 1'b0);
        chk_bit(page_act, 1'b0);
        chk_bit(pix_valid_q, 1'b0);
        chk_bit(main_wr, 1'b0);
        six = 1'b1;
        pix_chk(8'h5b, '{8'h58, 8'h48, 8'h78});
        six = 1'b0;
        u_wbl_host.wr(8'h10, 8'h5a);
        chk_bit(main_wr, 1'b1);
        chk_byte(main_addr, 8'h10);
        chk_byte(main_wdata, 8'h5a);
        u_wbl_host.rd(8'h10, rb);
        chk_byte(rb, `WBL_RST_RDATA);
        u_wbl_host.wr(`WBL_REG_PAGE_SEL, 8'h55);
        chk_bit(main_wr, 1'b1);
        chk_byte(main_wdata, 8'h55);
        chk_bit(page_act, 1'b0);
        for (c = 0; c < 3; c++) begin
            u_wbl_host.wr(`WBL_REG_PAGE_SEL, sel[c]);
            chk_bit(page_act, 1'b1);
            u_wbl_host.fill(key[c], 8'hff);
            u_wbl_host.rd(8'h7e, rb);
            chk_byte(rb, 8'h7e ^ key[c]);
            u_wbl_host.wr(`WBL_REG_PAGE_TOP, 8'h00);
            chk_bit(page_act, 1'b0);
        end
        chk_byte(n_main, 8'h02);
        chk_bit(wb_en, 1'b0);
        u_wbl_host.wr(`WBL_REG_PAGE_SEL, `WBL_CMD_ENABLE);
        chk_bit(wb_en, 1'b1);
        for (k = 0; k < 10; k++) begin
            @(posedge clk) #1;
            if (k >= 2) begin
                chk_pix(pix_out, ro[k-2]);
                chk_bit(pix_valid_q, 1'b1);
            end
            pix_valid = (k < 8);
            if (k < 8) pix_in = ri[k];
        end
        // Balanced 8-bit values pass whole in six-bit mode
        six = 1'b1;
        pix_chk(8'h01, ex(8'h01));
        six = 1'b0;
        u_wbl_host.wr(`WBL_REG_PAGE_SEL, `WBL_SEL_RED);
        u_wbl_host.wr(8'h03, 8'hc7);
        u_wbl_host.rd(8'h03, rb);
        chk_byte(rb, `WBL_RST_RDATA);
        u_wbl_host.wr(`WBL_REG_PAGE_TOP, 8'h00);
        pix_chk(8'h03, ex(8'h03));
        reload_en = 1'b1;
        repeat (3) @(posedge clk);
        u_wbl_host.wr(`WBL_REG_PAGE_SEL, `WBL_SEL_RED);
        u_wbl_host.wr(8'h03, 8'hc7);
        u_wbl_host.rd(8'h03, rb);
        chk_byte(rb, `WBL_RST_RDATA);
        u_wbl_host.wr(`WBL_REG_PAGE_TOP, 8'h00);
        rl = 1'b1;
        pix_chk(8'h03, ex(8'h03));
        pix_chk(8'h04, ex(8'h04));
        chk_bit(wb_en, 1'b1);
        // Mid-run reset: tables keep their contents and the load lock is lifted
        arst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 arst_n = 1'b1;
        chk_bit(wb_en, 1'b0);
        chk_bit(page_act, 1'b0);
        chk_bit(pix_valid_q, 1'b0);
        u_wbl_host.wr(`WBL_REG_PAGE_SEL, `WBL_SEL_RED);
        u_wbl_host.rd(8'h03, rb);
        chk_byte(rb, 8'hc7);
        u_wbl_host.wr(`WBL_REG_PAGE_TOP, 8'h00);
        chk_bit(page_act, 1'b0);
        complete_run();
    end
endmodule
